// ==== logic/sff_top.sv ====
`timescale 1ns/1ns
`include "sff_defines.svh"
module sff_top #(
    parameter int SMP_DIV = `SFF_SMP_DIV
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic i2c_clk,
    input wire sff_pkg::sff_cfg_t cfg,
    input wire sff_pkg::sff_adc_t [`SFF_N_CH-1:0] adc_in,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe,
    input wire logic sync_n_pin_i,
    output logic sync_n_pin_o,
    output logic sync_n_pin_oe,
    output logic alert_n,
    output logic frame_lost,
    input wire logic rd_open,
    input wire logic rd_next,
    input wire logic rd_stop,
    input wire logic drop_cmd,
    output logic rd_ack,
    output logic rd_nack,
    output logic [7:0] rd_data,
    output logic rd_data_valid,
    output logic [3:0] fifo_count,
    input wire logic ctl_start,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wr_byte,
    input wire logic ctl_rd,
    output logic ctl_ack,
    output logic [7:0] ctl_rd_byte,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_err,
    output logic stat_valid,
    output logic [7:0] stat_byte
);
    import sff_pkg::*;

    // ********************
    // helpers
    // ********************
    function automatic logic [4:0] g2b(input logic [4:0] g);
        logic [4:0] b;
        b[4] = g[4];
        for (int i = 3; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [4:0] b2g(input logic [4:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        return (p == `SFF_PTR_LAST) ? `SFF_PTR_FIRST : p + 5'h01;
    endfunction

    function automatic logic [3:0] ptr_idx(input logic [4:0] p);
        logic [4:0] v;
        v = p - `SFF_PTR_FIRST;
        return (v >= `SFF_N_FRAMES) ? 4'(v - `SFF_N_FRAMES) : v[3:0];
    endfunction

    function automatic logic [4:0] ptr_cnt(input logic [4:0] w, input logic [4:0] r);
        return (w >= r) ? w - r : w + `SFF_PTR_SPAN - r;
    endfunction

    // frame/byte to ram address
    function automatic logic [7:0] ram_addr(input logic [3:0] f, input logic [4:0] b);
        if (b == `SFF_FCNT0_BYTE) begin
            return {`SFF_FCNT0_HI, f};
        end else if (b == `SFF_FCNT1_BYTE) begin
            return {`SFF_FCNT1_HI, f};
        end
        return {f, 4'(b[3:0] + `SFF_CH_OFS)};
    endfunction

    logic [7:0] mem [256];
    logic master;
    logic tick;
    logic strobe;
    logic [15:0] div_q;
    logic clk_o_q;
    logic [7:0] smp_q;
    logic sync_n_q;
    logic clk_s1_q, clk_s2_q, clk_s3_q, syn_s1_q, syn_s2_q;
    logic [`SFF_N_CH-1:0] ch_en_l, en_s1_q, en_s2_q;
    logic [`SFF_ACC_W-1:0] acc_q [`SFF_N_CH];
    logic sat_q [`SFF_N_CH];
    logic [135:0] fvec;
    logic [135:0] fbuf_q;
    sff_wr_st_t wst_q;
    logic [4:0] wb_q, wptr_q, wgray_q, rg_s1_q, rg_s2_q, rptr_w, cnt_w;
    logic [15:0] fcnt_q;
    logic full_w, blocked, lock_s1_q, lock_s2_q, lost_q, alert_n_q;
    logic rl_s1_q, rst_l_q;
    sff_rd_st_t rst_q;
    logic [4:0] rb_q, rptr_q, rgray_q, wg_s1_q, wg_s2_q, wptr_r, cnt_r;
    logic empty_r, adv, ack_q, nack_q, dv_q;
    logic [7:0] rdat_q;
    logic [3:0] cnt_q;
    logic [7:0] ctl_q [`SFF_CTL_BYTES];
    logic [2:0] cb_q;
    logic cack_q, sv_q;
    logic [7:0] crb_q, sb_q;

    // ********************
    // sample timing, ref_clk domain
    // ********************
    assign master = !cfg.sync_slave;

    // pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            syn_s1_q <= 1'b1;
            syn_s2_q <= 1'b1;
        end else begin
            clk_s1_q <= clk_pin_i;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            syn_s1_q <= sync_n_pin_i;
            syn_s2_q <= syn_s1_q;
        end
    end

    // internal clock generator, idle in slave mode
    always_ff @(posedge ref_clk) begin
        if (rst || !master) begin
            div_q <= 16'h0000;
            clk_o_q <= 1'b0;
        end else if (div_q == 16'(SMP_DIV - 1)) begin
            div_q <= 16'h0000;
            clk_o_q <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            if (div_q == 16'(SMP_DIV / 2 - 1)) begin
                clk_o_q <= 1'b0;
            end
        end
    end

    // rising sample edge: own divider or the synchronised pin
    assign tick = master ? (div_q == 16'(SMP_DIV - 1)) : (clk_s2_q & ~clk_s3_q);
    assign strobe = tick && !(master ? sync_n_q : syn_s2_q);

    // strobe generator: low once per frame_rate_select+1 samples
    always_ff @(posedge ref_clk) begin
        if (rst || !master) begin
            smp_q <= 8'h00;
            sync_n_q <= 1'b1;
        end else if (tick) begin
            if (smp_q == cfg.frame_rate_select) begin
                smp_q <= 8'h00;
                sync_n_q <= 1'b0;
            end else begin
                smp_q <= smp_q + 8'h01;
                sync_n_q <= 1'b1;
            end
        end
    end

    // pins are driven only as master
    assign clk_pin_o = clk_o_q;
    assign clk_pin_oe = master;
    assign sync_n_pin_o = sync_n_q;
    assign sync_n_pin_oe = master;

    // channel enables cross as quasi-static levels
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_s1_q <= '1;
            en_s2_q <= '1;
        end else begin
            en_s1_q <= ch_en_l;
            en_s2_q <= en_s1_q;
        end
    end

    // ********************
    // accumulators
    // ********************
    for (genvar c = 0; c < `SFF_N_CH; c++) begin : g_ch
        logic [`SFF_ACC_W-1:0] sum;
        assign sum = acc_q[c] + `SFF_ACC_W'(adc_in[c].val);
        assign ch_en_l[c] = ctl_q[c][0];
        // disabled channel yields a zero word
        assign fvec[c*24 +: 24] = en_s2_q[c] ? {sat_q[c] | adc_in[c].sat, sum} : 24'h000000;

        // sum samples, clear on commit
        always_ff @(posedge ref_clk) begin
            if (rst || strobe) begin
                acc_q[c] <= '0;
                sat_q[c] <= 1'b0;
            end else if (tick) begin
                acc_q[c] <= sum;
                sat_q[c] <= sat_q[c] | adc_in[c].sat;
            end
        end
    end
    assign fvec[135:120] = fcnt_q;

    // ********************
    // write side
    // ********************
    assign rptr_w = g2b(rg_s2_q);
    assign cnt_w = ptr_cnt(wptr_q, rptr_w);
    assign full_w = (cnt_w == `SFF_N_FRAMES);
    assign blocked = full_w || (lock_s2_q && ptr_idx(wptr_q) == ptr_idx(rptr_w));

    // read pointer and lock into write domain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rg_s1_q <= `SFF_PTR_FIRST_G;
            rg_s2_q <= `SFF_PTR_FIRST_G;
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
            lock_s1_q <= (rst_q == RD_OPEN);
            lock_s2_q <= lock_s1_q;
        end
    end

    // frame writer: 17 bytes back to back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wst_q <= WR_IDLE;
            wb_q <= 5'h00;
            fbuf_q <= '0;
            lost_q <= 1'b0;
        end else begin
            lost_q <= 1'b0;
            case (wst_q)
                WR_IDLE: begin
                    if (strobe && blocked) begin
                        lost_q <= 1'b1;
                    end else if (strobe) begin
                        fbuf_q <= fvec;
                        wb_q <= 5'h00;
                        wst_q <= WR_BUSY;
                    end
                end
                WR_BUSY: begin
                    lost_q <= strobe;
                    wb_q <= wb_q + 5'h01;
                    if (wb_q == `SFF_FCNT1_BYTE) begin
                        wst_q <= WR_IDLE;
                    end
                end
                default: begin
                    wst_q <= WR_IDLE;
                end
            endcase
        end
    end

    // write pointer and frame counter advance after the last byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wptr_q <= `SFF_PTR_FIRST;
            wgray_q <= `SFF_PTR_FIRST_G;
            fcnt_q <= 16'h0000;
        end else if (wst_q == WR_BUSY && wb_q == `SFF_FCNT1_BYTE) begin
            wptr_q <= ptr_inc(wptr_q);
            wgray_q <= b2g(ptr_inc(wptr_q));
            fcnt_q <= fcnt_q + 16'h0001;
        end
    end

    // ram write port
    always_ff @(posedge ref_clk) begin
        if (wst_q == WR_BUSY) begin
            mem[ram_addr(ptr_idx(wptr_q), wb_q)] <= fbuf_q[{wb_q, 3'b000} +: 8];
        end
    end

    // alert low while data present and enabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alert_n_q <= 1'b1;
        end else begin
            alert_n_q <= !(cnt_w != 5'h00 && cfg.alert_en);
        end
    end
    assign alert_n = alert_n_q;
    assign frame_lost = lost_q;

    // ********************
    // read side, i2c_clk domain
    // ********************
    // reset and write pointer into link domain
    always_ff @(posedge i2c_clk) begin
        rl_s1_q <= rst;
        rst_l_q <= rl_s1_q;
        if (rst_l_q) begin
            wg_s1_q <= `SFF_PTR_FIRST_G;
            wg_s2_q <= `SFF_PTR_FIRST_G;
        end else begin
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
        end
    end

    assign wptr_r = g2b(wg_s2_q);
    assign cnt_r = ptr_cnt(wptr_r, rptr_q);
    assign empty_r = (cnt_r == 5'h00);
    assign adv = (rst_q == RD_OPEN && rd_stop && rb_q == 5'h11) || (drop_cmd && !empty_r);

    // frame reader
    always_ff @(posedge i2c_clk) begin
        if (rst_l_q) begin
            rst_q <= RD_IDLE;
            rb_q <= 5'h00;
            ack_q <= 1'b0;
            nack_q <= 1'b0;
            dv_q <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            ack_q <= 1'b0;
            nack_q <= 1'b0;
            dv_q <= 1'b0;
            case (rst_q)
                RD_IDLE: begin
                    if (rd_open && empty_r) begin
                        nack_q <= 1'b1;
                    end else if (rd_open) begin
                        ack_q <= 1'b1;
                        rb_q <= 5'h00;
                        rst_q <= RD_OPEN;
                    end
                end
                RD_OPEN: begin
                    if (rd_stop || drop_cmd) begin
                        rst_q <= RD_IDLE;
                    end else if (rd_next && rb_q != 5'h11) begin
                        rdat_q <= mem[ram_addr(ptr_idx(rptr_q), rb_q)];
                        dv_q <= 1'b1;
                        rb_q <= rb_q + 5'h01;
                    end
                end
                default: begin
                    rst_q <= RD_IDLE;
                end
            endcase
        end
    end

    // read pointer frees a frame on pop or drop
    always_ff @(posedge i2c_clk) begin
        if (rst_l_q) begin
            rptr_q <= `SFF_PTR_FIRST;
            rgray_q <= `SFF_PTR_FIRST_G;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_r[3:0];
            if (adv) begin
                rptr_q <= ptr_inc(rptr_q);
                rgray_q <= b2g(ptr_inc(rptr_q));
            end
        end
    end
    assign rd_ack = ack_q;
    assign rd_nack = nack_q;
    assign rd_data = rdat_q;
    assign rd_data_valid = dv_q;
    assign fifo_count = cnt_q;

    // channel control packet, five bytes each way
    always_ff @(posedge i2c_clk) begin
        if (rst_l_q) begin
            for (int i = 0; i < `SFF_CTL_BYTES; i++) begin
                ctl_q[i] <= `SFF_CTL_RST;
            end
            cb_q <= 3'h0;
            cack_q <= 1'b0;
            crb_q <= 8'h00;
        end else begin
            cack_q <= 1'b0;
            if (ctl_start) begin
                cb_q <= 3'h0;
            end else if (cb_q != `SFF_CTL_BYTES && ctl_wr) begin
                ctl_q[cb_q] <= ctl_wr_byte;
                cack_q <= 1'b1;
                cb_q <= cb_q + 3'h1;
            end else if (cb_q != `SFF_CTL_BYTES && ctl_rd) begin
                crb_q <= ctl_q[cb_q];
                cb_q <= cb_q + 3'h1;
            end
        end
    end
    assign ctl_ack = cack_q;
    assign ctl_rd_byte = crb_q;

    // status byte for set/reset commands
    always_ff @(posedge i2c_clk) begin
        if (rst_l_q) begin
            sv_q <= 1'b0;
            sb_q <= 8'h00;
        end else begin
            sv_q <= cmd_valid;
            if (cmd_valid) begin
                sb_q <= {cmd_code[5:0], cmd_err, ~cmd_err};
            end
        end
    end
    assign stat_valid = sv_q;
    assign stat_byte = sb_q;

    // ********************
    // assertions
    // ********************
    a_master_pins: assert property (@(posedge ref_clk) disable iff (rst)
        master |-> clk_pin_oe && sync_n_pin_oe)
        else $error("master pins not driven");
    a_master_clk: assert property (@(posedge ref_clk) disable iff (rst)
        master && tick |=> clk_pin_o)
        else $error("master clock not raised at tick");
    a_slave_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        !master |-> (!clk_pin_oe && !sync_n_pin_oe) ##1 (div_q == 16'h0000))
        else $error("slave drives pins");
    a_slave_fs: assert property (@(posedge ref_clk) disable iff (rst)
        !master |=> smp_q == 8'h00 && sync_n_q)
        else $error("slave uses rate select");
    a_commit_clear: assert property (@(posedge ref_clk) disable iff (rst)
        strobe |=> acc_q[0] == '0 && !sat_q[0])
        else $error("accumulator not cleared");
    a_full_drop: assert property (@(posedge ref_clk) disable iff (rst)
        strobe && wst_q == WR_IDLE && full_w |=> wst_q == WR_IDLE && lost_q)
        else $error("write while full");
    a_frame_whole: assert property (@(posedge ref_clk) disable iff (rst)
        strobe && wst_q == WR_IDLE && !blocked |=> wst_q == WR_BUSY && wb_q == 5'h00
        ##16 wb_q == `SFF_FCNT1_BYTE ##1 wst_q == WR_IDLE && $changed(wptr_q))
        else $error("frame write broken");
    a_alert_level: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 alert_n == !($past(cnt_w) != 5'h00 && $past(cfg.alert_en)))
        else $error("alert level wrong");
    a_count_max: assert property (@(posedge i2c_clk) disable iff (rst_l_q)
        !empty_r |=> fifo_count <= 4'hE && fifo_count != 4'h0)
        else $error("occupancy out of range");
    a_count_empty: assert property (@(posedge i2c_clk) disable iff (rst_l_q)
        empty_r |=> fifo_count == 4'h0)
        else $error("occupancy not zero when empty");
    a_nack_empty: assert property (@(posedge i2c_clk) disable iff (rst_l_q)
        rst_q == RD_IDLE && rd_open && empty_r |=> rd_nack && !rd_ack && rst_q == RD_IDLE)
        else $error("read on empty not refused");
    a_early_stop: assert property (@(posedge i2c_clk) disable iff (rst_l_q)
        rst_q == RD_OPEN && rd_stop && !drop_cmd && rb_q != 5'h11 |=> $stable(rptr_q))
        else $error("early stop moved pointer");
    a_stat_byte: assert property (@(posedge i2c_clk) disable iff (rst_l_q)
        cmd_valid |=> stat_valid && stat_byte[6:2] == $past(cmd_code[4:0])
        && stat_byte[1] == $past(cmd_err) && stat_byte[0] != $past(cmd_err))
        else $error("status byte wrong");
endmodule // sff_top

// ==== logic/sff_defines.svh ====
`ifndef SFF_DEFINES_SVH
`define SFF_DEFINES_SVH
// ********************
// timing
// ********************
`define SFF_REF_PERIOD_NS 20
`define SFF_SMP_PERIOD_NS 1000000
`define SFF_SMP_DIV (`SFF_SMP_PERIOD_NS / `SFF_REF_PERIOD_NS)
// ********************
// frame layout
// ********************
`define SFF_N_CH 5
`define SFF_ACC_W 23
`define SFF_N_FRAMES 5'h0E
`define SFF_FCNT0_BYTE 5'h0F
`define SFF_FCNT1_BYTE 5'h10
`define SFF_FCNT0_HI 4'hE
`define SFF_FCNT1_HI 4'hF
`define SFF_CH_OFS 4'h1
// ********************
// pointers, gray range 2..29 wraps with one bit change
// ********************
`define SFF_PTR_FIRST 5'h02
`define SFF_PTR_FIRST_G 5'h03
`define SFF_PTR_LAST 5'h1D
`define SFF_PTR_SPAN 5'h1C
// ********************
// channel control packet
// ********************
`define SFF_CTL_BYTES 3'h5
`define SFF_CTL_RST 8'h01
`endif

// ==== logic/sff_pkg.sv ====
package sff_pkg;
    // one filtered adc sample with its over-range flag
    typedef struct packed {
        logic sat;
        logic [14:0] val;
    } sff_adc_t;
    // front-end configuration bits used here
    typedef struct packed {
        logic sync_slave;
        logic alert_en;
        logic [7:0] frame_rate_select;
    } sff_cfg_t;
    typedef enum logic {WR_IDLE = 1'b0, WR_BUSY = 1'b1} sff_wr_st_t;
    typedef enum logic {RD_IDLE = 1'b0, RD_OPEN = 1'b1} sff_rd_st_t;
endpackage

// ==== tb/sff_sync_peer.sv ====
`timescale 1ns/1ns
// ****
// external timing master
// ****
module sff_sync_peer (
    input wire logic ref_clk,
    input wire logic run,
    output logic clk_o,
    output logic sync_n_o
);
    logic [5:0] cnt_q;
    // 40-cycle period while running, still otherwise
    always_ff @(posedge ref_clk) begin
        if (!run || cnt_q == 6'h27) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end
    assign clk_o = run && (cnt_q >= 6'h14);
    // strobe active across a whole burst
    assign sync_n_o = !run;
endmodule // sff_sync_peer

// ==== tb/sensor_frame_fifo_sync_bench.sv ====
`timescale 1ns/1ns
`include "sff_defines.svh"
// ****
// bench
// ****
module sensor_frame_fifo_sync_bench;
    import sff_pkg::*;
    logic ref_clk = 1'h0, i2c_clk = 1'h0, rst = 1'h1, run = 1'h0;
    logic rd_open = 1'h0, rd_next = 1'h0, rd_stop = 1'h0, drop_cmd = 1'h0;
    logic ctl_start = 1'h0, ctl_wr = 1'h0, ctl_rd = 1'h0, cmd_valid = 1'h0, cmd_err = 1'h0;
    logic [7:0] ctl_wr_byte = 8'h00, cmd_code = 8'h00;
    sff_cfg_t cfg = {1'h1, 1'h1, 8'h03};
    sff_adc_t [`SFF_N_CH-1:0] adc_in;
    logic peer_clk, peer_sync_n, clk_pin_o, clk_pin_oe, sync_n_pin_o, sync_n_pin_oe;
    logic alert_n, frame_lost, rd_ack, rd_nack, rd_data_valid, ctl_ack, stat_valid;
    logic [7:0] rd_data, ctl_rd_byte, stat_byte;
    logic [3:0] fifo_count;
    logic [4:0] en = 5'h1F;
    logic [7:0] fbuf [0:16];
    int n_mismatch = 0, total_checks = 0, i;
    time t_fall;
    // wire level from whoever drives it
    wire logic clk_pin_i = clk_pin_oe ? clk_pin_o : peer_clk;
    wire logic sync_n_pin_i = sync_n_pin_oe ? sync_n_pin_o : peer_sync_n;

    sff_sync_peer peer_u (.ref_clk(ref_clk), .run(run), .clk_o(peer_clk), .sync_n_o(peer_sync_n));
    sff_top #(.SMP_DIV(32)) dut_u (.ref_clk(ref_clk), .rst(rst), .i2c_clk(i2c_clk), .cfg(cfg),
        .adc_in(adc_in), .clk_pin_i(clk_pin_i), .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
        .sync_n_pin_i(sync_n_pin_i), .sync_n_pin_o(sync_n_pin_o), .sync_n_pin_oe(sync_n_pin_oe),
        .alert_n(alert_n), .frame_lost(frame_lost), .rd_open(rd_open), .rd_next(rd_next),
        .rd_stop(rd_stop), .drop_cmd(drop_cmd), .rd_ack(rd_ack), .rd_nack(rd_nack),
        .rd_data(rd_data), .rd_data_valid(rd_data_valid), .fifo_count(fifo_count),
        .ctl_start(ctl_start), .ctl_wr(ctl_wr), .ctl_wr_byte(ctl_wr_byte), .ctl_rd(ctl_rd),
        .ctl_ack(ctl_ack), .ctl_rd_byte(ctl_rd_byte), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_err(cmd_err), .stat_valid(stat_valid), .stat_byte(stat_byte));

    // clocks, unrelated phases
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #1;
        forever #3 i2c_clk = ~i2c_clk;
    end

    // expected frame byte k for an accumulation of mult samples
    function logic [7:0] exp_byte(input int k, input int mult, input logic [15:0] cnt);
        logic [23:0] w;
        if (k == 15) return cnt[7:0];
        if (k == 16) return cnt[15:8];
        w = en[k/3] ? {adc_in[k/3].sat, 23'(mult * adc_in[k/3].val)} : 24'h000000;
        return w[8*(k%3) +: 8];
    endfunction

    task chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one channel-control byte, either way
    task ctl_xfer(input logic wr, input logic [7:0] b, input logic ack, input logic [7:0] exp_rd);
        ctl_wr = wr;
        ctl_rd = !wr;
        ctl_wr_byte = b;
        @(negedge i2c_clk);
        ctl_wr = 1'h0;
        ctl_rd = 1'h0;
        chk(ctl_ack, wr & ack, "ctl ack");
        if (!wr) chk(ctl_rd_byte, exp_rd, "ctl byte");
        @(negedge i2c_clk);
    endtask

    task ctl_begin;
        ctl_start = 1'h1;
        @(negedge i2c_clk);
        ctl_start = 1'h0;
        @(negedge i2c_clk);
    endtask

    task cmd(input logic [7:0] code, input logic err);
        cmd_valid = 1'h1;
        cmd_code = code;
        cmd_err = err;
        @(negedge i2c_clk);
        cmd_valid = 1'h0;
        chk(stat_valid, 1'h1, "stat valid");
        chk(stat_byte, {code[5:0], err, !err}, "stat byte");
        @(negedge i2c_clk);
    endtask

    // open, n bytes back to back, wait, stop
    task rd_frame(input logic ack, input int n, input int hold);
        int k;
        rd_open = 1'h1;
        @(negedge i2c_clk);
        rd_open = 1'h0;
        chk({rd_ack, rd_nack}, {ack, !ack}, "open answer");
        if (ack && n > 0) begin
            rd_next = 1'h1;
            for (k = 0; k < n; k++) begin
                @(negedge i2c_clk);
                fbuf[k] = rd_data;
                chk(rd_data_valid, 1'h1, "byte valid");
            end
            rd_next = 1'h0;
        end
        repeat (hold) @(negedge i2c_clk);
        rd_stop = 1'h1;
        @(negedge i2c_clk);
        rd_stop = 1'h0;
        @(negedge i2c_clk);
    endtask

    task frame_cmp(input int mult, input logic [15:0] cnt);
        int k;
        for (k = 0; k < 17; k++) chk(fbuf[k], exp_byte(k, mult, cnt), "frame byte");
    endtask

    task wait_count(input logic [3:0] n);
        int k;
        for (k = 0; k < 8000 && fifo_count !== n; k++) @(negedge i2c_clk);
        chk(fifo_count, n, "fifo count");
    endtask

    initial begin
        #300000;
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog", $time);
        close_out();
    end

    // ****
    // tests
    // ****
    initial begin
        for (i = 0; i < `SFF_N_CH; i++) adc_in[i] = {(i == 4), 15'h7F01 + 15'(i)};
        repeat (2) @(negedge ref_clk);
        rst = 1'h0;
        repeat (5) @(negedge i2c_clk);
        // reset state in timing-slave mode
        chk({clk_pin_oe, sync_n_pin_oe}, 2'h0, "slave pins");
        chk(alert_n, 1'h1, "alert idle");
        chk(fifo_count, 4'h0, "count empty");
        rd_frame(1'h0, 0, 0);
        ctl_begin();
        for (i = 0; i < 6; i++) ctl_xfer(1'h0, 8'h00, 1'h0, 8'h01);
        $display("test reset done");
        // status replies, ok and error
        for (i = 0; i < 7; i++) cmd(8'h24 ^ 8'(i), i[0]);
        // host stops after the command byte, next command still answered
        cmd_valid = 1'h1;
        cmd_code = 8'h28;
        @(negedge i2c_clk);
        cmd_valid = 1'h0;
        rd_stop = 1'h1;
        @(negedge i2c_clk);
        rd_stop = 1'h0;
        cmd(8'h24, 1'h0);
        chk(stat_byte, 24'h000091, "wake reply");
        $display("test status done");
        // disable channel 2, sixth byte refused
        ctl_begin();
        for (i = 0; i < 5; i++) ctl_xfer(1'h1, (i == 2) ? 8'h00 : 8'h01, 1'h1, 8'h00);
        ctl_xfer(1'h1, 8'h01, 1'h0, 8'h00);
        en = 5'h1B;
        ctl_begin();
        for (i = 0; i < 5; i++) ctl_xfer(1'h0, 8'h00, 1'h0, (i == 2) ? 8'h00 : 8'h01);
        $display("test control done");
        // two strobed pulses from the external master
        @(negedge ref_clk);
        run = 1'h1;
        repeat (2) @(posedge peer_clk);
        repeat (10) @(negedge ref_clk);
        run = 1'h0;
        wait_count(4'h2);
        repeat (10) @(negedge ref_clk);
        chk(alert_n, 1'h0, "alert data");
        rd_frame(1'h1, 5, 0);
        repeat (20) @(negedge i2c_clk);
        chk(fifo_count, 4'h2, "early stop keeps");
        rd_frame(1'h1, 17, 0);
        frame_cmp(1, 16'h0000);
        wait_count(4'h1);
        repeat (40) @(negedge i2c_clk);
        drop_cmd = 1'h1;
        @(negedge i2c_clk);
        drop_cmd = 1'h0;
        wait_count(4'h0);
        repeat (10) @(negedge ref_clk);
        chk(alert_n, 1'h1, "alert empty");
        rd_frame(1'h0, 0, 0);
        $display("test slave done");
        // own master, two samples per frame
        @(negedge ref_clk);
        cfg = {1'h0, 1'h1, 8'h01};
        repeat (3) @(negedge ref_clk);
        chk({clk_pin_oe, sync_n_pin_oe}, 2'h3, "master pins");
        // sync pin period is two sample periods of 32 cycles each
        for (i = 0; i < 200 && sync_n_pin_o !== 1'h1; i++) @(negedge ref_clk);
        for (i = 0; i < 200 && sync_n_pin_o !== 1'h0; i++) @(negedge ref_clk);
        t_fall = $time;
        chk(clk_pin_o, 1'h1, "clk high at strobe");
        for (i = 0; i < 200 && sync_n_pin_o !== 1'h1; i++) @(negedge ref_clk);
        for (i = 0; i < 200 && sync_n_pin_o !== 1'h0; i++) @(negedge ref_clk);
        chk(24'(($time - t_fall) / 20), 24'h000040, "strobe period");
        wait_count(4'hE);
        for (i = 0; i < 300 && frame_lost !== 1'h1; i++) @(negedge ref_clk);
        chk(frame_lost, 1'h1, "lost when full");
        cfg.alert_en = 1'h0;
        repeat (5) @(negedge ref_clk);
        chk(alert_n, 1'h1, "alert masked");
        cfg.alert_en = 1'h1;
        repeat (5) @(negedge ref_clk);
        chk(alert_n, 1'h0, "alert unmasked");
        // read held open while full, frames arriving
        rd_frame(1'h1, 5, 200);
        rd_frame(1'h1, 17, 0);
        chk({fbuf[16], fbuf[15]}, 16'h0002, "locked frame");
        rd_frame(1'h1, 17, 0);
        frame_cmp(2, 16'h0003);
        $display("test master done");
        close_out();
    end
endmodule // sensor_frame_fifo_sync_bench
